//--- design/aprg_pkg.sv
// package: register map, field positions and constants for the adc power/reference/gain control block
`default_nettype none
package aprg_pkg;
    localparam logic [11:0] ADDR_GAIN_LOW = 12'h050;
    localparam logic [11:0] ADDR_POWER_CTRL = 12'h054;
    localparam logic [11:0] ADDR_REF_SELECT = 12'h058;
    localparam logic [11:0] ADDR_GAIN_HIGH = 12'h05C;
    localparam int PWR_PD_A_BIT = 0;
    localparam int PWR_PD_B_BIT = 1;
    localparam int PWR_RSVD_BIT = 2;
    localparam int PWR_APD_BIT = 3;
    localparam int PWR_DLY_LSB = 4;
    localparam int PWR_STS_A_BIT = 10;
    localparam int PWR_STS_B_BIT = 11;
    localparam int REF_LO_A_BIT = 12;
    localparam int REF_HI_A_BIT = 13;
    localparam int REF_LO_B_BIT = 14;
    localparam int REF_HI_B_BIT = 15;
    localparam int DLY_WIDTH = 6;
    localparam logic [5:0] DLY_RESET = 6'd13;
    localparam logic [1:0] PD_RESET = 2'b11;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        PS_OFF = 2'b00,
        PS_SETTLE = 2'b01,
        PS_ON = 2'b10
    } aprg_pstate_t;
endpackage
`default_nettype wire

//--- design/aprg_top.sv
// top: axi4-lite register bank controlling adc power-down, references and input gains
// Overview of operation
// [R1] Setting converter B power-down bit removes its power at once.
// [R2] Setting converter A power-down bit removes its power at once.
// [R3] Converter B results are flagged invalid while its power-down bit is set.
// [R4] Converter A results are flagged invalid while its power-down bit is set.
// [R5] Converter B powered continuously, or only on scan demand under auto-powerdown.
// [R6] Converter A powered continuously, or only on scan demand under auto-powerdown.
// [R7] Software waits the power-up delay before scanning outside auto-powerdown.
// [R8] A readable per-converter power status bit shows settling has finished.
// [R9] Power register bit 2 is read-only and always reads one.
// [R10] Bits 15/14 pick converter 1 high/low reference: internal or bank B input.
// [R11] Bits 13/12 pick converter 0 high/low reference: internal or bank A input.
// [R12] Reference register bits 11 to 4 are read-only zero.
// [R13] Gain field 00 unity, 01 x2, 10 x4, 11 reserved; input 7 at 15:14.
// [R14] Sixteen gain fields: bank A inputs 0-7, then bank B inputs 0-7.
// [R15] Bank A input 6 gain at bits 13:12, input 5 at 11:10.
// [R16] Six-bit power-up delay counts adc clocks; default thirteen.
// [R17] Status set at once on power-down; clears after delay once released.
// [R18] Writes to read-only reserved bits are ignored.
`default_nettype none
module aprg_top
    import aprg_pkg::*;
#(
    parameter int NUM_CHANNELS = 16
)(
    input wire logic sys_clk, // system clock, 40 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic clk_en, // freezes all state while low, except pending write/read responses still clear on ready
    input wire logic adc_clk_tick, // one-cycle adc clock strobe, same domain
    input wire logic scan_need_a, // scan requires converter A
    input wire logic scan_need_b, // scan requires converter B
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic conv_a_power_on, // converter A supply enable
    output logic conv_b_power_on, // converter B supply enable
    output logic conv_a_result_invalid, // converter A results unusable
    output logic conv_b_result_invalid, // converter B results unusable
    output logic high_ref_src_conv0, // 1: bank A input 2
    output logic low_ref_src_conv0, // 1: bank A input 3
    output logic high_ref_src_conv1, // 1: bank B input 2
    output logic low_ref_src_conv1, // 1: bank B input 3
    output logic [2*NUM_CHANNELS-1:0] amp_sel // 2-bit gain per channel
);
    if (NUM_CHANNELS != 16)
    begin : g_bad_channels
        $error("aprg_top supports exactly 16 channels");
    end

    logic rst_s1_n, rst_n_sync;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_n <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_s1_n <= 1'b1;
            rst_n_sync <= rst_s1_n;
        end
    end

    // register state
    logic [1:0] pd_reg, pd_next;
    logic apd_reg, apd_next;
    logic [DLY_WIDTH-1:0] dly_reg, dly_next;
    logic [3:0] ref_reg, ref_next;
    logic [31:0] gain_reg, gain_next;
    // bus state
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [11:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    // power sequencers
    aprg_pstate_t pst_reg [2], pst_next [2];
    logic [DLY_WIDTH-1:0] cnt_reg [2], cnt_next [2];
    logic [1:0] sts;

    function automatic logic known_addr(input logic [11:0] a);
        return (a == ADDR_GAIN_LOW) || (a == ADDR_POWER_CTRL) ||
            (a == ADDR_REF_SELECT) || (a == ADDR_GAIN_HIGH);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0])
            r[7:0] = d[7:0];
        if (st[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    logic wr_fire, aw_have, w_have;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [15:0] pwr_word, ref_word, m;

    assign aw_have = aw_got_reg || s_axi_awvalid;
    assign w_have = w_got_reg || s_axi_wvalid;
    assign wr_addr = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_got_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_got_reg ? w_strb_reg : s_axi_wstrb;
    assign wr_fire = clk_en && aw_have && w_have && !bvalid_reg;
    assign s_axi_awready = clk_en && !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = clk_en && !w_got_reg && !bvalid_reg;
    assign s_axi_arready = clk_en && !rvalid_reg;

    always_comb
    begin
        pwr_word = 16'h0000;
        pwr_word[PWR_PD_A_BIT] = pd_reg[0];
        pwr_word[PWR_PD_B_BIT] = pd_reg[1];
        pwr_word[PWR_RSVD_BIT] = 1'b1; // R9
        pwr_word[PWR_APD_BIT] = apd_reg;
        pwr_word[PWR_DLY_LSB +: DLY_WIDTH] = dly_reg;
        pwr_word[PWR_STS_A_BIT] = sts[0]; // R8
        pwr_word[PWR_STS_B_BIT] = sts[1]; // R8
        ref_word = 16'h0000; // R12
        ref_word[REF_HI_B_BIT:REF_LO_A_BIT] = ref_reg;
    end

    always_comb
    begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        pd_next = pd_reg;
        apd_next = apd_reg;
        dly_next = dly_reg;
        ref_next = ref_reg;
        gain_next = gain_reg;
        m = 16'h0000;
        if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_next = 1'b1;
                aw_addr_next = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_next = 1'b1;
                w_data_next = s_axi_wdata;
                w_strb_next = s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_next = 1'b0;
                w_got_next = 1'b0;
                bvalid_next = 1'b1;
                bresp_next = known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
                if (wr_addr == ADDR_POWER_CTRL)
                begin
                    // read-only status and reserved bits are not stored
                    m = merge16(pwr_word, wr_data, wr_strb); // R18
                    pd_next = {m[PWR_PD_B_BIT], m[PWR_PD_A_BIT]}; // R1 R2
                    apd_next = m[PWR_APD_BIT];
                    dly_next = m[PWR_DLY_LSB +: DLY_WIDTH]; // R16
                end
                else if (wr_addr == ADDR_REF_SELECT)
                begin
                    m = merge16(ref_word, wr_data, wr_strb);
                    ref_next = m[REF_HI_B_BIT:REF_LO_A_BIT]; // R18
                end
                else if (wr_addr == ADDR_GAIN_LOW)
                    gain_next[15:0] = merge16(gain_reg[15:0], wr_data, wr_strb); // R15
                else if (wr_addr == ADDR_GAIN_HIGH)
                    gain_next[31:16] = merge16(gain_reg[31:16], wr_data, wr_strb); // R14
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_next = 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_next = 1'b1;
                rresp_next = RESP_OKAY;
                rdata_next = 32'h0000_0000;
                if (s_axi_araddr == ADDR_GAIN_LOW)
                    rdata_next[15:0] = gain_reg[15:0];
                else if (s_axi_araddr == ADDR_POWER_CTRL)
                    rdata_next[15:0] = pwr_word;
                else if (s_axi_araddr == ADDR_REF_SELECT)
                    rdata_next[15:0] = ref_word;
                else if (s_axi_araddr == ADDR_GAIN_HIGH)
                    rdata_next[15:0] = gain_reg[31:16];
                else
                    rresp_next = RESP_SLVERR;
            end
            else if (rvalid_reg && s_axi_rready)
                rvalid_next = 1'b0;
        end
        if (!clk_en && bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        if (!clk_en && rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    // per-converter power sequencer
    logic [1:0] need;
    assign need = {scan_need_b, scan_need_a};
    for (genvar c = 0; c < 2; c++)
    begin : g_pwr
        always_comb
        begin
            pst_next[c] = pst_reg[c];
            cnt_next[c] = cnt_reg[c];
            if (clk_en)
            begin
                case (pst_reg[c])
                    PS_OFF:
                    begin
                        // leave off when released and (no auto mode or a scan asks)
                        if (!pd_next[c] && (!apd_next || need[c])) // R5 R6
                        begin
                            pst_next[c] = PS_SETTLE;
                            cnt_next[c] = dly_next; // R16
                        end
                    end
                    PS_SETTLE:
                    begin
                        if (pd_next[c] || (apd_next && !need[c]))
                            pst_next[c] = PS_OFF; // R1 R2 R5 R6
                        else if (cnt_reg[c] == '0)
                            pst_next[c] = PS_ON; // R17
                        else if (adc_clk_tick)
                            cnt_next[c] = cnt_reg[c] - 1'b1; // R16
                    end
                    PS_ON:
                    begin
                        if (pd_next[c] || (apd_next && !need[c]))
                            pst_next[c] = PS_OFF; // R1 R2 R5 R6
                    end
                    default: pst_next[c] = PS_OFF;
                endcase
            end
        end
        always_ff @(posedge sys_clk or negedge rst_n_sync)
        begin
            if (!rst_n_sync)
            begin
                pst_reg[c] <= PS_OFF;
                cnt_reg[c] <= '0;
            end
            else
            begin
                pst_reg[c] <= pst_next[c];
                cnt_reg[c] <= cnt_next[c];
            end
        end
        // status high means powered down / not yet settled
        assign sts[c] = pd_reg[c] || (pst_reg[c] != PS_ON); // R8 R17
    end

    always_ff @(posedge sys_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            pd_reg <= PD_RESET;
            apd_reg <= 1'b0;
            dly_reg <= DLY_RESET;
            ref_reg <= 4'h0;
            gain_reg <= {GAIN_RESET, GAIN_RESET};
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pd_reg <= pd_next;
            apd_reg <= apd_next;
            dly_reg <= dly_next;
            ref_reg <= ref_next;
            gain_reg <= gain_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    // power stays on through settling so the converter can stabilise
    assign conv_a_power_on = !pd_reg[0] && (pst_reg[0] != PS_OFF); // R2 R6
    assign conv_b_power_on = !pd_reg[1] && (pst_reg[1] != PS_OFF); // R1 R5
    assign conv_a_result_invalid = pd_reg[0]; // R4
    assign conv_b_result_invalid = pd_reg[1]; // R3
    assign high_ref_src_conv1 = ref_reg[REF_HI_B_BIT-REF_LO_A_BIT]; // R10
    assign low_ref_src_conv1 = ref_reg[REF_LO_B_BIT-REF_LO_A_BIT]; // R10
    assign high_ref_src_conv0 = ref_reg[REF_HI_A_BIT-REF_LO_A_BIT]; // R11
    assign low_ref_src_conv0 = ref_reg[0]; // R11
    assign amp_sel = gain_reg; // R13 R14

    chk_pd_a_cuts_power: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R2
        pd_reg[0] |-> !conv_a_power_on) else $error("converter A powered while down");
    chk_pd_b_cuts_power: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R1
        pd_reg[1] |-> !conv_b_power_on) else $error("converter B powered while down");
    chk_invalid_b_flag: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R3
        wr_fire && wr_addr == ADDR_POWER_CTRL && wr_strb[0] && wr_data[PWR_PD_B_BIT]
        |=> conv_b_result_invalid) else $error("B invalid flag wrong");
    chk_invalid_a_flag: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R4
        wr_fire && wr_addr == ADDR_POWER_CTRL && wr_strb[0] && wr_data[PWR_PD_A_BIT]
        |=> conv_a_result_invalid) else $error("A invalid flag wrong");
    chk_stay_on_b: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R5
        clk_en && !pd_reg[1] && !apd_reg && pst_reg[1] == PS_ON && !pd_next[1] && !apd_next
        |=> conv_b_power_on) else $error("B dropped outside auto mode");
    chk_auto_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R6
        clk_en && apd_next && !need[0] |=> !conv_a_power_on) else $error("A kept on without demand");
    chk_status_tracks: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R8
        pst_reg[0] == PS_ON && !pd_reg[0] |-> !pwr_word[PWR_STS_A_BIT]) else $error("status stuck");
    chk_rsvd_one: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R9
        s_axi_rvalid && s_axi_rresp == RESP_OKAY && $past(s_axi_araddr) == ADDR_POWER_CTRL && $rose(s_axi_rvalid)
        |-> s_axi_rdata[PWR_RSVD_BIT]) else $error("reserved bit not one");
    chk_ref_zero: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R12
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == ADDR_REF_SELECT
        |-> s_axi_rdata[11:4] == 8'h00) else $error("reference reserved bits nonzero");
    sequence s_release_a;
        clk_en && pst_reg[0] == PS_OFF && pst_next[0] == PS_SETTLE && dly_next == 6'h00;
    endsequence
    chk_settle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R17
        s_release_a ##1 (clk_en && !pd_next[0]) |=> pst_reg[0] == PS_ON) else $error("zero delay not honoured");
    chk_pd_sets_sts: assert property (@(posedge sys_clk) disable iff (!rst_n_sync) // R17
        $rose(pd_reg[1]) |-> pwr_word[PWR_STS_B_BIT]) else $error("status not set at power-down");
endmodule
`default_nettype wire

//--- verification/aprg_tb.sv
// testbench: register access, power sequencing and reset checks for the adc control block
`default_nettype none
module testbench
    import aprg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] rd; logic [1:0] rs; logic [31:0] ob;} aprg_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic adc_clk_tick = 1'b0;
    logic scan_need_a = 1'b0;
    logic scan_need_b = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d, amp_sel;
    logic conv_a_power_on, conv_b_power_on, conv_a_result_invalid, conv_b_result_invalid;
    logic high_ref_src_conv0, low_ref_src_conv0, high_ref_src_conv1, low_ref_src_conv1;
    logic [1:0] tick_div = 2'd0;
    int tick_cnt = 0, t0, fails = 0, n_tests = 0;
    aprg_row_t rows [7] = '{
        '{ADDR_GAIN_LOW, 4'hF, 32'hFFFF_93E4, 32'h0000_93E4, RESP_OKAY, 32'h0000_93E4},
        '{ADDR_GAIN_HIGH, 4'hF, 32'h0000_1234, 32'h0000_1234, RESP_OKAY, 32'h1234_93E4},
        '{ADDR_GAIN_HIGH, 4'h1, 32'h0000_00FF, 32'h0000_12FF, RESP_OKAY, 32'h12FF_93E4},
        '{ADDR_GAIN_HIGH, 4'h2, 32'h0000_AB00, 32'h0000_ABFF, RESP_OKAY, 32'hABFF_93E4},
        '{ADDR_REF_SELECT, 4'hF, 32'h0000_AFFF, 32'h0000_A000, RESP_OKAY, 32'h0000_000A},
        '{ADDR_REF_SELECT, 4'hF, 32'h0000_5000, 32'h0000_5000, RESP_OKAY, 32'h0000_0005},
        '{12'h060, 4'hF, 32'h0000_FFFF, 32'h0000_0000, RESP_SLVERR, 32'hABFF_93E4}
    };
    aprg_top u_aprg_top (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .adc_clk_tick(adc_clk_tick),
        .scan_need_a(scan_need_a), .scan_need_b(scan_need_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conv_a_power_on(conv_a_power_on), .conv_b_power_on(conv_b_power_on),
        .conv_a_result_invalid(conv_a_result_invalid), .conv_b_result_invalid(conv_b_result_invalid),
        .high_ref_src_conv0(high_ref_src_conv0), .low_ref_src_conv0(low_ref_src_conv0),
        .high_ref_src_conv1(high_ref_src_conv1), .low_ref_src_conv1(low_ref_src_conv1), .amp_sel(amp_sel));
    always #12.5 sys_clk = ~sys_clk;
    // adc clock strobe every fourth system cycle
    always @(posedge sys_clk)
    begin
        tick_div <= tick_div + 2'd1;
        adc_clk_tick <= tick_div == 2'd3;
        if (adc_clk_tick)
            tick_cnt <= tick_cnt + 1;
    end
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", name, e, s);
            fails++;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // handshake sampled at the negedge before the taking edge, released right after it
    task automatic wr(input logic [11:0] a, input logic [3:0] s, input logic [31:0] v, output logic [1:0] rs);
        logic aw_hit;
        logic w_hit;
        logic done;
        logic aw_seen;
        logic w_seen;
        done = 1'b0;
        aw_seen = 1'b0;
        w_seen = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(negedge sys_clk);
            aw_hit = s_axi_awvalid && s_axi_awready === 1'b1;
            w_hit = s_axi_wvalid && s_axi_wready === 1'b1;
            aw_seen = aw_seen || aw_hit;
            w_seen = w_seen || w_hit;
            done = s_axi_bvalid === 1'b1;
            rs = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_hit)
                s_axi_awvalid <= 1'b0;
            if (w_hit)
                s_axi_wvalid <= 1'b0;
            if (done)
                s_axi_bready <= 1'b0;
        end
        check("write taken", 2'b11, {aw_seen, w_seen});
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar_hit;
        logic done;
        logic ar_seen;
        done = 1'b0;
        ar_seen = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(negedge sys_clk);
            ar_hit = s_axi_arvalid && s_axi_arready === 1'b1;
            ar_seen = ar_seen || ar_hit;
            done = s_axi_rvalid === 1'b1;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_hit)
                s_axi_arvalid <= 1'b0;
            if (done)
                s_axi_rready <= 1'b0;
        end
        check("read taken", 1, ar_seen);
    endtask
    task automatic rst_chk();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        idle(3);
        check("reset power on", 0, {conv_b_power_on, conv_a_power_on});
        check("reset invalid", 3, {conv_b_result_invalid, conv_a_result_invalid});
        check("reset outputs", 0, {high_ref_src_conv1, low_ref_src_conv1, high_ref_src_conv0, low_ref_src_conv0, amp_sel[27:0]});
        rd(ADDR_POWER_CTRL, d, r);
        check("reset power reg", 32'h0000_0CD7, d);
        rd(ADDR_REF_SELECT, d, r);
        check("reset ref reg", 32'h0000_0000, d);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        check("watchdog", 1, 0);
        complete_run();
    end
    initial
    begin
        rst_chk();
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].s, rows[i].d, r);
            check("write resp", rows[i].rs, r);
            rd(rows[i].a, d, r);
            check("read resp", rows[i].rs, r);
            check("read data", rows[i].rd, d);
            idle(0);
            check("outputs", rows[i].ob, rows[i].a == ADDR_REF_SELECT ?
                {28'h0, high_ref_src_conv1, low_ref_src_conv1, high_ref_src_conv0, low_ref_src_conv0} : amp_sel);
        end
        $display("test register rows done");
        t0 = tick_cnt;
        wr(ADDR_POWER_CTRL, 4'hF, 32'h0000_0C30, r);
        idle(1);
        check("power on", 3, {conv_b_power_on, conv_a_power_on});
        check("invalid off", 0, {conv_b_result_invalid, conv_a_result_invalid});
        rd(ADDR_POWER_CTRL, d, r);
        check("power settling", 32'h0000_0C34, d);
        for (int n = 0; n < 30 && d[11:10] !== 2'b00; n++)
            rd(ADDR_POWER_CTRL, d, r);
        check("settle ticks", 1, (tick_cnt - t0) >= 3 && (tick_cnt - t0) <= 5);
        check("power settled", 32'h0000_0034, d);
        $display("test power up done");
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_POWER_CTRL, 4'hF, k == 0 ? 32'h0000_0031 : 32'h0000_0033, r);
            idle(0);
            check("pd power on", k == 0 ? 2 : 0, {conv_b_power_on, conv_a_power_on});
            check("pd invalid", k == 0 ? 1 : 3, {conv_b_result_invalid, conv_a_result_invalid});
            rd(ADDR_POWER_CTRL, d, r);
            check("pd status", k == 0 ? 32'h0000_0435 : 32'h0000_0C37, d);
        end
        $display("test power down done");
        wr(ADDR_POWER_CTRL, 4'hF, 32'h0000_0038, r);
        idle(20);
        check("auto idle", 0, {conv_b_power_on, conv_a_power_on});
        @(posedge sys_clk);
        scan_need_a <= 1'b1;
        idle(20);
        check("auto need a", 1, {conv_b_power_on, conv_a_power_on});
        rd(ADDR_POWER_CTRL, d, r);
        check("auto status", 32'h0000_083C, d);
        scan_need_a <= 1'b0;
        scan_need_b <= 1'b1;
        idle(20);
        check("auto need b", 2, {conv_b_power_on, conv_a_power_on});
        @(posedge sys_clk);
        scan_need_b <= 1'b0;
        idle(20);
        check("auto released", 0, {conv_b_power_on, conv_a_power_on});
        $display("test auto powerdown done");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        scan_need_a <= 1'b1;
        idle(20);
        check("frozen power", 0, {conv_b_power_on, conv_a_power_on});
        check("frozen ready", 0, {s_axi_awready, s_axi_wready, s_axi_arready});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        idle(20);
        check("thawed power", 1, {conv_b_power_on, conv_a_power_on});
        @(posedge sys_clk);
        scan_need_a <= 1'b0;
        $display("test clock enable done");
        wr(ADDR_POWER_CTRL, 4'hF, 32'h0000_0000, r);
        rd(ADDR_POWER_CTRL, d, r);
        check("zero delay", 32'h0000_0004, d);
        check("zero delay on", 3, {conv_b_power_on, conv_a_power_on});
        $display("test zero delay done");
        rst_chk();
        complete_run();
    end
endmodule
`default_nettype wire
